// *** src/tcic_top.v ***
// capture input filter, edge prescaler and channel control registers
`include "tcic_defines.vh"

module tcic_top
(
    input wire clock,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire chan0_pin_input,
    input wire chan1_pin_input,
    input wire chan2_pin_input,
    input wire chan3_pin_input,
    input wire internal_trigger_sel,
    output reg [3:0] chan_filtered_r,
    output reg [3:0] chan_selected_input_r,
    output reg [3:0] chan_capture_r
);

    // ==========================================
    // rate and length decode

    function [3:0] flt_len;
        input [3:0] code;
        begin
            case (code)
                4'h0: flt_len = `TCIC_N1;
                4'h1: flt_len = `TCIC_N2;
                4'h2: flt_len = `TCIC_N4;
                4'h3: flt_len = `TCIC_N8;
                4'hA: flt_len = `TCIC_N5;
                4'hB: flt_len = `TCIC_N6;
                4'hC: flt_len = `TCIC_N8;
                4'hD: flt_len = `TCIC_N5;
                4'hE: flt_len = `TCIC_N6;
                4'hF: flt_len = `TCIC_N8;
                default: flt_len = code[0] ? `TCIC_N8 : `TCIC_N6;
            endcase
        end
    endfunction

    function [2:0] psc_term;
        input [1:0] code;
        begin
            case (code)
                2'h0: psc_term = `TCIC_PSC_T1;
                2'h1: psc_term = `TCIC_PSC_T2;
                2'h2: psc_term = `TCIC_PSC_T4;
                default: psc_term = `TCIC_PSC_T8;
            endcase
        end
    endfunction

    // ==========================================
    // sample rate enables
    // dts runs at the kernel clock here, so code 0 samples every cycle
    reg [4:0] prediv_r;
    reg en_d2_r;
    reg en_d4_r;
    reg en_d8_r;
    reg en_d16_r;
    reg en_d32_r;

    always @(posedge clock)
    begin
        if (rst)
        begin
            prediv_r <= 5'h00;
            en_d2_r <= 1'b0;
            en_d4_r <= 1'b0;
            en_d8_r <= 1'b0;
            en_d16_r <= 1'b0;
            en_d32_r <= 1'b0;
        end
        else
        begin
            prediv_r <= prediv_r + 5'h01;
            en_d2_r <= (prediv_r[0] == 1'b1);
            en_d4_r <= (prediv_r[1:0] == 2'h3);
            en_d8_r <= (prediv_r[2:0] == 3'h7);
            en_d16_r <= (prediv_r[3:0] == 4'hF);
            en_d32_r <= (prediv_r == 5'h1F);
        end
    end

    // ==========================================
    // registers
    reg [7:0] ctl_r [0:3];
    reg [3:0] chen_r;
    wire [3:0] pin_raw;
    wire acc_w;
    wire wr_w;
    // filter outputs gathered so a channel can read its neighbour
    wire [3:0] filt_w;

    assign pin_raw = {chan3_pin_input, chan2_pin_input, chan1_pin_input, chan0_pin_input};
    // a write lands only at the edge where pready is seen high
    assign acc_w = psel & penable & pready;
    assign wr_w = acc_w & pwrite;

    always @(posedge clock)
    begin
        if (rst)
        begin
            chen_r <= `TCIC_RST_CHEN;
        end
        else if (wr_w && paddr == `TCIC_OFS_CHEN)
        begin
            chen_r <= pwdata[3:0];
        end
    end

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1)
        begin : g_ch
            wire wsel;
            wire [7:0] wbyte;
            reg [1:0] sync_r;
            reg [3:0] fcnt_r;
            reg filt_r;
            reg sel_d_r;
            reg [2:0] pcnt_r;
            reg samp_en;
            reg sel_in;
            wire [3:0] fcode;
            wire [1:0] ms;
            wire [1:0] psc;
            // high for one cycle per rising edge of the selected input
            wire edge_w;

            // low byte even, high byte odd
            assign wsel = wr_w && (paddr == ((g < 2) ? `TCIC_OFS_CHAN01 : `TCIC_OFS_CHAN23));
            assign wbyte = (g % 2 == 1) ? pwdata[15:8] : pwdata[7:0];
            assign fcode = ctl_r[g][`TCIC_FLT_HI:`TCIC_FLT_LO];
            assign ms = ctl_r[g][`TCIC_MS_HI:`TCIC_MS_LO];

            always @(posedge clock)
            begin
                if (rst)
                begin
                    ctl_r[g] <= `TCIC_RST_CTL;
                end
                else if (wsel)
                begin
                    ctl_r[g][`TCIC_FLT_HI:`TCIC_PSC_LO] <= wbyte[`TCIC_FLT_HI:`TCIC_PSC_LO];
                    if (!chen_r[g])
                    begin
                        ctl_r[g][`TCIC_MS_HI:`TCIC_MS_LO] <= wbyte[`TCIC_MS_HI:`TCIC_MS_LO];
                    end
                end
            end

            // off and kernel codes every cycle
            always @*
            begin
                if (fcode <= `TCIC_FLT_KCK_LAST)
                    samp_en = 1'b1;
                else if (fcode <= `TCIC_FLT_D2_LAST)
                    samp_en = en_d2_r;
                else if (fcode <= `TCIC_FLT_D4_LAST)
                    samp_en = en_d4_r;
                else if (fcode <= `TCIC_FLT_D8_LAST)
                    samp_en = en_d8_r;
                else if (fcode <= `TCIC_FLT_D16_LAST)
                    samp_en = en_d16_r;
                else
                    samp_en = en_d32_r;
            end

            always @(posedge clock)
            begin
                if (rst)
                begin
                    sync_r <= 2'h0;
                    fcnt_r <= 4'h0;
                    filt_r <= 1'b0;
                end
                else
                begin
                    sync_r <= {sync_r[0], pin_raw[g]};
                    if (samp_en)
                    begin
                        if (sync_r[1] == filt_r)
                        begin
                            fcnt_r <= 4'h0;
                        end
                        else if (fcnt_r + 4'h1 >= flt_len(fcode))
                        begin
                            fcnt_r <= 4'h0;
                            filt_r <= sync_r[1];
                        end
                        else
                        begin
                            fcnt_r <= fcnt_r + 4'h1;
                        end
                    end
                end
            end

            // ==========================================
            // input selection and edge prescaler
            // the partner channel reads this filter through filt_w
            assign filt_w[g] = filt_r;

            assign psc = ctl_r[g][`TCIC_PSC_HI:`TCIC_PSC_LO];

            // own, neighbour or trigger
            // neighbour pairs are 0/1 and 2/3, hence g ^ 1
            always @*
            begin
                case (ms)
                    `TCIC_MS_OWN: sel_in = filt_r;
                    `TCIC_MS_NBR: sel_in = filt_w[g ^ 1];
                    `TCIC_MS_TRG: sel_in = internal_trigger_sel;
                    default: sel_in = 1'b0;
                endcase
            end

            // rising edges only; no polarity control lives here
            // a mode write can itself make an edge, so set modes while disabled
            assign edge_w = sel_in & ~sel_d_r & (ms != `TCIC_MS_OUT);

            // count rests at zero, so the first capture is the Nth edge
            always @(posedge clock)
            begin
                if (rst)
                begin
                    sel_d_r <= 1'b0;
                    pcnt_r <= 3'h0;
                    chan_capture_r[g] <= 1'b0;
                end
                else
                begin
                    sel_d_r <= sel_in;
                    chan_capture_r[g] <= 1'b0;
                    if (!chen_r[g])
                    begin
                        pcnt_r <= 3'h0;
                    end
                    else if (edge_w)
                    begin
                        if (pcnt_r >= psc_term(psc))
                        begin
                            pcnt_r <= 3'h0;
                            chan_capture_r[g] <= 1'b1;
                        end
                        else
                        begin
                            pcnt_r <= pcnt_r + 3'h1;
                        end
                    end
                end
            end

            // one more stage keeps the ports straight from flip-flops
            always @(posedge clock)
            begin
                if (rst)
                begin
                    chan_filtered_r[g] <= 1'b0;
                    chan_selected_input_r[g] <= 1'b0;
                end
                else
                begin
                    chan_filtered_r[g] <= filt_r;
                    chan_selected_input_r[g] <= sel_in;
                end
            end
        end
    endgenerate

    // ==========================================
    // apb slave: one wait state, then pready for one cycle
    // full-word accesses assumed, no strobes
    // upper half not stored, reads zero
    always @(posedge clock)
    begin
        if (rst)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
        else
        begin
            pready <= psel & penable & ~pready;
            if (psel && penable && !pready)
            begin
                pslverr <= 1'b0;
                prdata <= 32'h00000000;
                case (paddr)
                    `TCIC_OFS_CHAN01: prdata[15:0] <= {ctl_r[1], ctl_r[0]};
                    `TCIC_OFS_CHAN23: prdata[15:0] <= {ctl_r[3], ctl_r[2]};
                    `TCIC_OFS_CHEN: prdata[3:0] <= chen_r;
                    `TCIC_OFS_STAT: prdata[7:0] <= {chan_selected_input_r, chan_filtered_r};
                    default: pslverr <= 1'b1;
                endcase
            end
            else if (pready)
            begin
                pslverr <= 1'b0;
            end
        end
    end

endmodule // tcic_top

// *** src/tcic_defines.vh ***
// constants for the capture input conditioning block
`ifndef TCIC_DEFINES_VH
`define TCIC_DEFINES_VH

// ==========================================
// register byte offsets
`define TCIC_OFS_CHAN01 12'h018
`define TCIC_OFS_CHAN23 12'h01C
`define TCIC_OFS_CHEN 12'h020
`define TCIC_OFS_STAT 12'h024

// ==========================================
// reset values
`define TCIC_RST_CTL 8'h00
`define TCIC_RST_CHEN 4'h0

// ==========================================
// per-channel byte layout
`define TCIC_FLT_HI 7
`define TCIC_FLT_LO 4
`define TCIC_PSC_HI 3
`define TCIC_PSC_LO 2
`define TCIC_MS_HI 1
`define TCIC_MS_LO 0

// ==========================================
// mode selection codes
`define TCIC_MS_OUT 2'h0
`define TCIC_MS_OWN 2'h1
`define TCIC_MS_NBR 2'h2
`define TCIC_MS_TRG 2'h3

// ==========================================
// filter codes that bound each sample rate group
`define TCIC_FLT_KCK_LAST 4'h3
`define TCIC_FLT_D2_LAST 4'h5
`define TCIC_FLT_D4_LAST 4'h7
`define TCIC_FLT_D8_LAST 4'h9
`define TCIC_FLT_D16_LAST 4'hC

// ==========================================
// filter lengths
`define TCIC_N1 4'h1
`define TCIC_N2 4'h2
`define TCIC_N4 4'h4
`define TCIC_N5 4'h5
`define TCIC_N6 4'h6
`define TCIC_N8 4'h8

// ==========================================
// prescaler terminal counts (edges per capture minus one)
`define TCIC_PSC_T1 3'h0
`define TCIC_PSC_T2 3'h1
`define TCIC_PSC_T4 3'h3
`define TCIC_PSC_T8 3'h7

`endif

// *** tb/tcic_pin_model.sv ***
// pin driver standing in for the external capture sources
module tcic_pin_model
(
    input wire clock,
    input wire [3:0] lvl,
    output logic [3:0] pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // ======
    // levels move only after an edge, like a slow external source
    initial pin = 4'h0;
    always @(posedge clock)
        pin <= lvl;
endmodule // tcic_pin_model

// *** tb/tcic_properties.sv ***
// port assertions for the capture conditioning block
module tcic_props
(
    input wire clock,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire chan1_pin_input,
    input wire [3:0] chan_filtered_r,
    input wire [3:0] chan_selected_input_r,
    input wire [3:0] chan_capture_r
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // ======
    property p_rdy; psel && penable && !pready |=> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("ready late");
    property p_one; pready |=> !pready; endproperty
    a_one: assert property (p_one) else $error("ready too long");
    property p_err; pslverr |-> pready && !(paddr inside {12'h018, 12'h01C, 12'h020, 12'h024}); endproperty
    a_err: assert property (p_err) else $error("bad error");
    property p_hi; pready && !pwrite && paddr[11:3] == 9'h003 |-> prdata[31:16] == 16'h0000; endproperty
    a_hi: assert property (p_hi) else $error("upper bits set");
    property p_rst; disable iff (1'b0) rst |=> chan_capture_r == 4'h0 && chan_filtered_r == 4'h0 && !pready; endproperty
    a_rst: assert property (p_rst) else $error("reset value");
    property p_cap; chan_capture_r[0] |-> chan_selected_input_r[0] && (!$past(chan_selected_input_r[0]) || !$past(chan_selected_input_r[0], 2)); endproperty
    a_cap: assert property (p_cap) else $error("capture without edge");
    property p_cap1; chan_capture_r[0] |=> !chan_capture_r[0]; endproperty
    a_cap1: assert property (p_cap1) else $error("capture too long");
    property p_flt; $changed(chan_filtered_r[1]) |-> chan_filtered_r[1] == $past(chan1_pin_input, 4) || chan_filtered_r[1] == $past(chan1_pin_input, 5); endproperty
    a_flt: assert property (p_flt) else $error("filter moved alone");
    property p_hold; !pready |-> $stable(prdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
endmodule // tcic_props

// *** tb/tcic_top_tb.sv ***
// testbench for the capture input conditioning block
`include "tcic_defines.vh"
module tcic_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, trig = 0, e;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, q;
    logic [3:0] lvl = 4'h0;
    wire [31:0] prdata;
    wire pready, pslverr;
    wire [3:0] pins, filt, sel, cap;
    int num_errors = 0, n_checks = 0, ncap = 0, ncap1 = 0, c0, bad, dv, nn;
    initial forever #5 clock = ~clock;
    always @(posedge clock) if (cap[0] === 1'b1) ncap <= ncap + 1;
    always @(posedge clock) if (cap[1] === 1'b1) ncap1 <= ncap1 + 1;
    tcic_pin_model pm (.clock(clock), .lvl(lvl), .pin(pins));
    tcic_top uut (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .chan0_pin_input(pins[0]), .chan1_pin_input(pins[1]), .chan2_pin_input(pins[2]),
        .chan3_pin_input(pins[3]), .internal_trigger_sel(trig), .chan_filtered_r(filt),
        .chan_selected_input_r(sel), .chan_capture_r(cap));
    // ======
    task automatic end_sim;
        if (num_errors == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
        n_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        i = 0;
        do
        begin
            @(posedge clock);
            i++;
        end while (pready !== 1'b1 && i < 20);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            num_errors++;
            end_sim;
        end
        @(posedge clock);
    endtask
    task automatic hold(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic pulses(input logic [3:0] m, input int n);
        repeat (n)
        begin
            lvl <= lvl | m;
            hold(6);
            lvl <= lvl & ~m;
            hold(6);
        end
        hold(8);
    endtask
    function automatic int fdiv(input int c);
        if (c < 4)
            return 1;
        if (c < 10)
            return 1 << ((c - 2) / 2);
        return (c < 13) ? 16 : 32;
    endfunction
    function automatic int flen(input int c);
        if (c < 4)
            return 1 << c;
        if (c < 10)
            return (c % 2) ? 8 : 6;
        return ((c - 10) % 3 == 0) ? 5 : ((c - 10) % 3 == 1) ? 6 : 8;
    endfunction
    // ======
    initial
    begin
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        for (int k = 0; k < 3; k++)
        begin
            apb(1'b0, 12'h018 + 12'(4 * k), 32'h00000000);
            chk(q, 32'h00000000, "reset value");
        end
        apb(1'b1, `TCIC_OFS_CHAN23, 32'h0000A5B6);
        apb(1'b0, `TCIC_OFS_CHAN23, 32'h00000000);
        chk(q, 32'h0000A5B6, "chan23 layout");
        apb(1'b1, `TCIC_OFS_CHEN, 32'h00000004);
        apb(1'b1, `TCIC_OFS_CHAN23, 32'h00005AB4);
        apb(1'b0, `TCIC_OFS_CHAN23, 32'h00000000);
        chk(q, 32'h00005AB6, "mode lock");
        apb(1'b0, 12'h030, 32'h00000000);
        chk({31'h0, e}, 32'h00000001, "unmapped error");
        apb(1'b1, `TCIC_OFS_CHEN, 32'h00000000);
        for (int c = 1; c < 16; c++)
        begin
            dv = fdiv(c);
            nn = flen(c);
            apb(1'b1, `TCIC_OFS_CHAN01, 32'(c << 12 | 32'h100));
            lvl[1] <= 1'b1;
            hold((nn - 1) * dv);
            lvl[1] <= 1'b0;
            bad = 0;
            repeat ((nn + 1) * dv + 8)
            begin
                @(negedge clock);
                bad |= (filt[1] !== 1'b0);
            end
            chk(bad, 0, "short pulse");
            @(posedge clock);
            lvl[1] <= 1'b1;
            hold((nn + 1) * dv + 8);
            chk(filt[1], 1'b1, "long pulse");
            lvl[1] <= 1'b0;
            hold((nn + 1) * dv + 8);
        end
        for (int p = 0; p < 4; p++)
        begin
            apb(1'b1, `TCIC_OFS_CHAN01, 32'(p << 2 | 1));
            apb(1'b1, `TCIC_OFS_CHEN, 32'h00000001);
            c0 = ncap;
            pulses(4'h1, 8);
            chk(ncap - c0, 8 >> p, "captures");
            apb(1'b1, `TCIC_OFS_CHEN, 32'h00000000);
        end
        apb(1'b1, `TCIC_OFS_CHEN, 32'h00000001);
        c0 = ncap;
        pulses(4'h1, 4);
        apb(1'b1, `TCIC_OFS_CHEN, 32'h00000000);
        apb(1'b1, `TCIC_OFS_CHEN, 32'h00000001);
        pulses(4'h1, 4);
        chk(ncap - c0, 0, "cleared divider");
        apb(1'b1, `TCIC_OFS_CHEN, 32'h00000000);
        apb(1'b1, `TCIC_OFS_CHAN01, 32'h00000900);
        apb(1'b1, `TCIC_OFS_CHEN, 32'h00000002);
        c0 = ncap1;
        pulses(4'h2, 8);
        chk(ncap1 - c0, 2, "ch1 captures");
        apb(1'b1, `TCIC_OFS_CHEN, 32'h00000000);
        for (int k = 0; k < 5; k++)
        begin
            apb(1'b1, `TCIC_OFS_CHAN01, 32'(10'h0F9 >> (2 * k) & 3));
            trig <= (k > 2);
            lvl <= {2'h0, 1'b1, k > 2};
            hold(10);
            chk(sel[0], 5'h0A >> k & 1, "selected input");
            apb(1'b0, `TCIC_OFS_STAT, 32'h00000000);
            chk(q, 32'(((5'h0A >> k & 1) << 4) | 2 | (k > 2)), "status");
        end
        end_sim;
    end
endmodule // tcic_top_tb
bind tcic_top tcic_props u_props (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chan1_pin_input(chan1_pin_input), .chan_filtered_r(chan_filtered_r),
    .chan_selected_input_r(chan_selected_input_r), .chan_capture_r(chan_capture_r));
